// ---- hdl/tsc_cfg.svh ----
// Purpose: Constants for the tile status and control register bank
// Assumes: Register numbers are processor-status numbers, not byte addresses
// Notes:   Included by the design module and the verification files
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH
// ****************************************
// Register numbers
// ****************************************
`define TSC_REG_CTRL      8'h02
`define TSC_REG_BOOT      8'h03
`define TSC_REG_SEC       8'h05
`define TSC_REG_OSC_CTRL  8'h06
`define TSC_REG_OSC_VAL0  8'h07
`define TSC_REG_OSC_VAL1  8'h08
`define TSC_REG_OSC_VAL2  8'h09
`define TSC_REG_OSC_VAL3  8'h0a
`define TSC_RID_LOW       8'h0b
// ****************************************
// Writable masks and reset values
// ****************************************
`define TSC_CTRL_MASK     32'h03ff_ff36
`define TSC_CTRL_RST      32'h0000_0000
`define TSC_BOOT_MASK     32'h00ff_013f
`define TSC_SEC_MASK      32'h8000_5fb1
`define TSC_SEC_LOCK      31
`define TSC_OSC_MASK      32'h0000_0003
`define TSC_OSC_RST       32'h0000_0000
// ****************************************
// Field positions
// ****************************************
`define TSC_TXDLY_HI      25
`define TSC_TXDLY_LO      18
`define TSC_TXDIV_HI      17
`define TSC_TXDIV_LO      9
`define TSC_RGMII_EN      8
`define TSC_DYN_SEL       5
`define TSC_DIV_EN        4
`define TSC_UTMI_SEL      2
`define TSC_ULPI_EN       1
`define TSC_SEC_GDBG      14
`define TSC_SEC_ALLLOCK   12
`define TSC_SEC_LOCK_HI   11
`define TSC_SEC_LOCK_LO   8
`define TSC_SEC_REDUN     7
`define TSC_SEC_OTPBOOT   5
`define TSC_SEC_JTAGCFG   4
`define TSC_SEC_JTAGTAP   0
`define TSC_OSC_CORE      1
`define TSC_OSC_PERIPH    0
`define TSC_ZERO32        32'h0000_0000
// ****************************************
// Counter constants
// ****************************************
`define TSC_RING_CORE     2
`define TSC_CNT_INIT      16'h0000
`define TSC_CNT_STEP      16'h0001
`define TSC_TXCNT_STEP    9'h001
`endif

// ---- hdl/tsc_pkg.sv ----
// Purpose: Types for the tile status and control register bank
// Assumes: Nothing beyond the constants header
// Notes:   Holds the register selection type
package tsc_pkg;
  typedef enum logic [3:0] {
    TSC_SEL_NONE = 4'b0000,
    TSC_SEL_CTRL = 4'b0001,
    TSC_SEL_BOOT = 4'b0010,
    TSC_SEL_SEC  = 4'b0011,
    TSC_SEL_OSC  = 4'b0100,
    TSC_SEL_VAL  = 4'b0101
  } tsc_sel_t;
endpackage : tsc_pkg

// ---- hdl/tsc_regs.sv ----
// Purpose: Processor-status register bank of one tile: control, boot, security, oscillators
// Assumes: Reads and writes arrive as one-cycle strobes with a status resource identifier
// Notes:   Ring-oscillator counters live in their own clock domains, unreset
`timescale 1ns/1ps
`include "tsc_cfg.svh"

// Behaviour
// R1: Eight-bit transmit data delay field, read-write, resets to zero.
// R2: Transmit clock rises at counter equal divider, falls at divider shifted right one.
// R3: Software writes divider as ratio minus one.
// R4: Control bit 8 enables the RGMII peripheral ports, resets zero.
// R5: Control bit 4 enables the low-power PLL divider, resets zero.
// R6: Bit 5 picks dynamic mode, dividing only while all active threads pause.
// R7: Bit 2 selects UTMI when one, ULPI when zero.
// R8: Bit 1 enables the ULPI hardware support module.
// R9: Boot status bits 23 to 16 report the processor number.
// R10: Boot bits 1:0 PLL mode pins, bit 2 JTAG boot, bit 3 RAM boot.
// R11: Boot bit 5 core1 off, bit 4 skip read-level polling, bit 8 override.
// R12: Security bit 31 set blocks further writes to the security register.
// R13: Security bit 14 blocks global debug, bit 0 blocks JTAG debug port.
// R14: Security bit 12 locks all sectors, bits 11 to 8 lock one each.
// R15: Security bit 7 enables redundancy, bit 5 forces boot from OTP.
// R16: Security bit 4 keeps JTAG from PLL and boot configuration.
// R17: Security register loads from one-time-programmable memory.
// R18: Four free-running ring oscillators each clock a counter, started by control.
// R19: Oscillator bit 1 enables core oscillators, bit 0 peripheral ones; reset zero.
// R20: Software reads counters only after ten stopped core cycles.
// R21: Oscillators run asynchronous to the tile clock as a random source.
// R22: Each counter reads as sixteen bits, not cleared by system reset.
// R23: Resource identifier is register number shifted left eight, ORed with 0x0B.
// R24: Reserved and read-only bits read zero and ignore writes.
module tsc_regs
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Processor-status access
  input  wire logic        ps_wr,
  input  wire logic        ps_rd,
  input  wire logic [15:0] ps_rid,
  input  wire logic [31:0] ps_wdata,
  output logic      [31:0] ps_rdata,
  output logic             ps_ack,
  output logic             ps_err,
  // PLL output clock and thread state
  input  wire logic        pll_clk,
  input  wire logic        all_paused,
  // Boot straps and OTP security image
  input  wire logic [31:0] boot_status_in,
  input  wire logic        otp_load,
  input  wire logic [31:0] otp_security,
  // Ring oscillator clocks
  input  wire logic [3:0]  ring_clk,
  // Control outputs
  output logic [7:0]       rgmii_tx_delay,
  output logic             rgmii_tx_clk,
  output logic             rgmii_port_en,
  output logic             pll_div_active,
  output logic             usb_utmi_sel,
  output logic             ulpi_hw_en,
  output logic [31:0]      security_cfg,
  output logic [1:0]       ring_osc_en
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic tsc_sel_t decode(input logic [15:0] rid);
    if (rid[7:0] != `TSC_RID_LOW) begin // see R23
      return TSC_SEL_NONE;
    end
    case (rid[15:8])
      `TSC_REG_CTRL:     return TSC_SEL_CTRL;
      `TSC_REG_BOOT:     return TSC_SEL_BOOT;
      `TSC_REG_SEC:      return TSC_SEL_SEC;
      `TSC_REG_OSC_CTRL: return TSC_SEL_OSC;
      `TSC_REG_OSC_VAL0,
      `TSC_REG_OSC_VAL1,
      `TSC_REG_OSC_VAL2,
      `TSC_REG_OSC_VAL3: return TSC_SEL_VAL;
      default:           return TSC_SEL_NONE;
    endcase
  endfunction : decode

  // Decoded access and register state
  tsc_sel_t    sel;
  logic [1:0]  val_idx;
  logic        acc_any;
  logic        unmapped;
  logic        wr_ctrl;
  logic        wr_sec;
  logic        wr_osc;
  logic        sec_wr_ok;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] sec_q, sec_d;
  logic [31:0] osc_q, osc_d;
  logic [31:0] boot_word;
  logic [31:0] val_word;
  logic [31:0] rd_mux;
  logic [15:0] ring_cnt [4];

  // Selection of the register addressed; any other identifier is unmapped
  assign sel       = decode(ps_rid);
  assign val_idx   = 2'(ps_rid[15:8] - `TSC_REG_OSC_VAL0);
  assign acc_any   = ps_rd || ps_wr;
  assign unmapped  = (sel == TSC_SEL_NONE);

  // Write strobes per register; a locked security register takes no write
  assign sec_wr_ok = !sec_q[`TSC_SEC_LOCK]; // see R12
  assign wr_ctrl   = ps_wr && (sel == TSC_SEL_CTRL);
  assign wr_sec    = ps_wr && (sel == TSC_SEL_SEC) && sec_wr_ok; // see R12
  assign wr_osc    = ps_wr && (sel == TSC_SEL_OSC);

  // ****************************************
  // Writable registers
  // ****************************************
  // Next values keep only writable bits
  assign ctrl_d = wr_ctrl ? (ps_wdata & `TSC_CTRL_MASK) : ctrl_q; // see R1 R24
  assign osc_d  = wr_osc ? (ps_wdata & `TSC_OSC_MASK) : osc_q; // see R18 R19
  // The OTP image wins over a write in the same cycle, lock or no lock
  assign sec_d  = otp_load ? (otp_security & `TSC_SEC_MASK) : // see R17
                  wr_sec ? (ps_wdata & `TSC_SEC_MASK) : sec_q; // see R12

  // Register state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `TSC_CTRL_RST;
      sec_q  <= `TSC_ZERO32;
      osc_q  <= `TSC_OSC_RST; // see R19
    end else begin
      ctrl_q <= ctrl_d;
      sec_q  <= sec_d;
      osc_q  <= osc_d;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Boot straps masked to their defined fields, counter zero-extended
  assign boot_word = boot_status_in & `TSC_BOOT_MASK; // see R9 R10 R11 R24
  assign val_word  = {16'h0000, ring_cnt[val_idx]}; // see R22

  // Read data multiplexer, reserved bits zero
  assign rd_mux = (sel == TSC_SEL_CTRL) ? ctrl_q :
                  (sel == TSC_SEL_BOOT) ? boot_word :
                  (sel == TSC_SEL_SEC)  ? sec_q :
                  (sel == TSC_SEL_OSC)  ? osc_q :
                  (sel == TSC_SEL_VAL)  ? val_word :
                  `TSC_ZERO32;

  // Answer values: data only on reads, error on an unmapped identifier
  logic [31:0] rdata_d;
  logic        ack_d;
  logic        err_d;
  assign rdata_d = ps_rd ? rd_mux : `TSC_ZERO32;
  assign ack_d   = acc_any; // see R23
  assign err_d   = acc_any && unmapped; // see R23

  // Read data, standing one cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ps_rdata <= `TSC_ZERO32;
    end else begin
      ps_rdata <= rdata_d;
    end
  end

  // Acknowledge and error, one-cycle pulses
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ps_ack <= 1'b0;
      ps_err <= 1'b0;
    end else begin
      ps_ack <= ack_d;
      ps_err <= err_d;
    end
  end

  // ****************************************
  // Control outputs
  // ****************************************
  // Divider activity when enabled: static mode always, dynamic mode only while all paused
  logic        div_act_d;
  assign div_act_d = ctrl_q[`TSC_DIV_EN] &&
                     (!ctrl_q[`TSC_DYN_SEL] || all_paused); // see R5 R6

  // Transmit delay and port enable
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rgmii_tx_delay <= '0;
      rgmii_port_en  <= 1'b0;
    end else begin
      rgmii_tx_delay <= ctrl_q[`TSC_TXDLY_HI:`TSC_TXDLY_LO]; // see R1
      rgmii_port_en  <= ctrl_q[`TSC_RGMII_EN]; // see R4
    end
  end

  // Clock divider activity
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pll_div_active <= 1'b0;
    end else begin
      pll_div_active <= div_act_d; // see R5 R6
    end
  end

  // Transceiver interface selection
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      usb_utmi_sel <= 1'b0;
      ulpi_hw_en   <= 1'b0;
    end else begin
      usb_utmi_sel <= ctrl_q[`TSC_UTMI_SEL]; // see R7
      ulpi_hw_en   <= ctrl_q[`TSC_ULPI_EN]; // see R8
    end
  end

  // Security image and oscillator enables
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      security_cfg <= `TSC_ZERO32;
      ring_osc_en  <= '0;
    end else begin
      security_cfg <= sec_q; // see R13 R14 R15 R16
      ring_osc_en  <= osc_q[`TSC_OSC_CORE:`TSC_OSC_PERIPH]; // see R19
    end
  end

  // ****************************************
  // RGMII transmit clock, PLL domain
  // ****************************************
  logic [8:0] div_s1_q, div_s2_q, div_s3_q, div_q, div_d;
  logic [8:0] tx_cnt_q, tx_cnt_d;
  logic       div_take;
  logic       tx_wrap;
  logic       tx_rise;
  logic       tx_fall;
  logic       tx_clk_q, tx_clk_d;

  // Divider field brought over by two flops; a third copy lets the word be
  // taken only once two successive samples agree, so no torn value is used
  always_ff @(posedge pll_clk or negedge nrst) begin
    if (!nrst) begin
      div_s1_q <= '0;
      div_s2_q <= '0;
      div_s3_q <= '0;
    end else begin
      div_s1_q <= ctrl_q[`TSC_TXDIV_HI:`TSC_TXDIV_LO];
      div_s2_q <= div_s1_q;
      div_s3_q <= div_s2_q;
    end
  end

  // Settled divider value
  assign div_take = (div_s2_q == div_s3_q);
  assign div_d    = div_take ? div_s3_q : div_q;
  always_ff @(posedge pll_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // Counter wraps at the divider value, so the period is the field plus one
  assign tx_wrap  = (tx_cnt_q >= div_q);
  assign tx_rise  = (tx_cnt_q == div_q); // see R2
  assign tx_fall  = (tx_cnt_q == (div_q >> 1)); // see R2
  assign tx_cnt_d = tx_wrap ? '0 : 9'(tx_cnt_q + `TSC_TXCNT_STEP); // see R3
  assign tx_clk_d = tx_rise ? 1'b1 : (tx_fall ? 1'b0 : tx_clk_q);

  // Transmit counter and clock
  always_ff @(posedge pll_clk or negedge nrst) begin
    if (!nrst) begin
      tx_cnt_q <= '0;
      tx_clk_q <= 1'b0;
    end else begin
      tx_cnt_q <= tx_cnt_d;
      tx_clk_q <= tx_clk_d;
    end
  end
  assign rgmii_tx_clk = tx_clk_q;

  // ****************************************
  // Ring oscillator counters, own domains
  // ****************************************
  // Counters 0 and 1 follow the core enable, 2 and 3 the peripheral one
  for (genvar g = 0; g < 4; g++) begin : g_ring
    logic        en_src;
    logic        en_s1_q, en_s2_q;
    logic [15:0] cnt_d;
    // Power-up value zero; system reset leaves the count alone
    logic [15:0] cnt_q = `TSC_CNT_INIT; // see R22
    assign en_src = (g < `TSC_RING_CORE) ?
                    osc_q[`TSC_OSC_CORE] : osc_q[`TSC_OSC_PERIPH]; // see R19
    assign cnt_d  = en_s2_q ? 16'(cnt_q + `TSC_CNT_STEP) : cnt_q; // see R18
    // Enable synchronised into the oscillator domain, then the count
    always_ff @(posedge ring_clk[g]) begin // see R21
      en_s1_q <= en_src;
      en_s2_q <= en_s1_q;
      cnt_q   <= cnt_d;
    end
    assign ring_cnt[g] = cnt_q;
  end

endmodule : tsc_regs

// ---- verification/tsc_regs_monitor.sv ----
// Purpose: Port checks of the tile status and control register bank
// Assumes: Control outputs follow a write two cycles later
// Notes:   Bound to tsc_regs
`timescale 1ns/1ps
`include "tsc_cfg.svh"
module tsc_regs_monitor (
  // Clock, reset, access
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        ps_wr,
  input wire logic        ps_rd,
  input wire logic [15:0] ps_rid,
  input wire logic [31:0] ps_wdata,
  input wire logic [31:0] ps_rdata,
  input wire logic        ps_ack,
  input wire logic        ps_err,
  // Straps and outputs
  input wire logic [31:0] boot_status_in,
  input wire logic        otp_load,
  input wire logic [7:0]  rgmii_tx_delay,
  input wire logic        rgmii_port_en,
  input wire logic        pll_div_active,
  input wire logic        usb_utmi_sel,
  input wire logic        ulpi_hw_en,
  input wire logic [31:0] security_cfg,
  input wire logic [1:0]  ring_osc_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Write decodes
  wire wr_ctrl = ps_wr && ps_rid == 16'h020b;
  wire wr_osc  = ps_wr && ps_rid == 16'h060b;
  AST_ACK: assert property ((ps_wr || ps_rd) |=> ps_ack) else $error("no ack");
  AST_ERR: assert property (ps_rd && ps_rid == 16'h040b |=> ps_err) else $error("no err");
  AST_DLY: assert property (wr_ctrl |=> ##1 rgmii_tx_delay == $past(ps_wdata[25:18], 2))
    else $error("delay field");
  AST_BITS: assert property (wr_ctrl |=> ##1
    {rgmii_port_en, usb_utmi_sel, ulpi_hw_en} == $past({ps_wdata[8], ps_wdata[2:1]}, 2))
    else $error("control bits");
  AST_DIV: assert property (wr_ctrl && !(ps_wdata[5] && ps_wdata[4]) |=> ##1
    pll_div_active == $past(ps_wdata[4], 2)) else $error("divider");
  AST_OSC: assert property (wr_osc |=> ##1 ring_osc_en == $past(ps_wdata[1:0], 2))
    else $error("osc enable");
  AST_LOCK: assert property ((security_cfg[31] && !otp_load)[*3] |-> $stable(security_cfg))
    else $error("locked security changed");
  AST_BOOT: assert property (ps_rd && ps_rid == 16'h030b |=>
    ps_rdata == ($past(boot_status_in) & `TSC_BOOT_MASK)) else $error("boot word");
  // Main scenarios
  cover property (wr_ctrl && ps_wdata[5] && ps_wdata[4]);
  cover property (ps_err);
  cover property (security_cfg[31] && ps_wr && ps_rid == 16'h050b);
endmodule : tsc_regs_monitor
bind tsc_regs tsc_regs_monitor u_mon (.mclk, .nrst, .ps_wr, .ps_rd, .ps_rid, .ps_wdata,
  .ps_rdata, .ps_ack, .ps_err, .boot_status_in, .otp_load, .rgmii_tx_delay, .rgmii_port_en,
  .pll_div_active, .usb_utmi_sel, .ulpi_hw_en, .security_cfg, .ring_osc_en);

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for the tile status and control register bank
// Assumes: One-cycle strobes, answer one cycle later
// Notes:   PLL and ring clocks run at unrelated periods
`timescale 1ns/1ps
`include "tsc_cfg.svh"
module tb;
  logic        mclk = 0, nrst = 0, ps_wr = 0, ps_rd = 0, pll_clk = 0, all_paused = 0;
  logic        otp_load = 0, ps_ack, ps_err, rgmii_tx_clk, rgmii_port_en, pll_div_active;
  logic        usb_utmi_sel, ulpi_hw_en;
  logic [15:0] ps_rid = 0;
  logic [15:0] cnt [4];
  logic [31:0] ps_wdata = 0, boot_status_in = 0, otp_security = 0, ps_rdata, security_cfg;
  logic [31:0] rd, w;
  logic [3:0]  ring_clk = 0;
  logic [7:0]  rgmii_tx_delay;
  logic [1:0]  ring_osc_en;
  int          fail_count = 0, samples_checked = 0, n;
  tsc_regs dut (.mclk, .nrst, .ps_wr, .ps_rd, .ps_rid, .ps_wdata, .ps_rdata, .ps_ack, .ps_err,
    .pll_clk, .all_paused, .boot_status_in, .otp_load, .otp_security, .ring_clk,
    .rgmii_tx_delay, .rgmii_tx_clk, .rgmii_port_en, .pll_div_active, .usb_utmi_sel,
    .ulpi_hw_en, .security_cfg, .ring_osc_en);
  // Clocks
  initial forever #2 mclk = ~mclk;
  initial forever #3.1 pll_clk = ~pll_clk;
  initial forever #1.3 ring_clk = ring_clk + 4'h1;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One strobe, then the answer one cycle later
  task automatic acc(input logic wr, input int num, input logic [31:0] d);
    @(posedge mclk) #1;
    ps_wr = wr;
    ps_rd = !wr;
    ps_rid = {num[7:0], `TSC_RID_LOW};
    ps_wdata = d;
    @(posedge mclk) #1;
    ps_wr = 0;
    ps_rd = 0;
    chk({ps_ack, ps_err}, {1'b1, num == 4});
    rd = ps_rdata;
  endtask : acc
  // Expected read-back of a register after a write
  function automatic logic [31:0] expv(input int num, input logic [31:0] d);
    case (num)
      2: return d & `TSC_CTRL_MASK;
      3: return boot_status_in & `TSC_BOOT_MASK;
      5: return d & `TSC_SEC_MASK;
      default: return d & `TSC_OSC_MASK;
    endcase
  endfunction : expv
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
  // Main sequence
  initial begin
    rd = $urandom(32'h8bc98339);
    boot_status_in = $urandom;
    repeat (5) @(posedge mclk);
    #1 nrst = 1;
    for (n = 2; n < 7; n++) begin
      acc(0, n, 0);
      if (n != 4) chk(rd, expv(n, 0));
    end
    repeat (40) begin
      n = 2 + $urandom % 5;
      w = ($urandom % 4 == 0) ? 32'h7fff_ffff : $urandom & 32'h7fff_ffff;
      all_paused = $urandom;
      acc(1, n, w);
      acc(0, n, 0);
      if (n != 4) chk(rd, expv(n, w));
    end
    acc(1, 2, 32'h0000_0600);
    repeat (12) @(posedge pll_clk);
    n = 0;
    repeat (40) @(negedge pll_clk) n += rgmii_tx_clk;
    chk(n, 20);
    all_paused = 0;
    acc(1, 2, 32'h0000_0030);
    repeat (3) @(posedge mclk);
    #1 chk(pll_div_active, 0);
    all_paused = 1;
    repeat (3) @(posedge mclk);
    #1 chk(pll_div_active, 1);
    otp_security = $urandom | 32'h8000_0000;
    otp_load = 1;
    @(posedge mclk) #1 otp_load = 0;
    acc(1, 5, 0);
    acc(0, 5, 0);
    chk(rd, otp_security & `TSC_SEC_MASK);
    chk(security_cfg, otp_security & `TSC_SEC_MASK);
    acc(1, 6, 3);
    repeat (50) @(posedge mclk);
    acc(1, 6, 0);
    repeat (20) @(posedge mclk);
    for (n = 0; n < 4; n++) begin
      acc(0, 7 + n, 0);
      cnt[n] = rd[15:0];
      chk({rd[31:16], 15'h0, $isunknown(rd)}, 0);
      chk(cnt[n] != 16'h0000, 1);
    end
    nrst = 0;
    repeat (2) @(posedge mclk);
    #1 nrst = 1;
    for (n = 0; n < 4; n++) begin
      acc(0, 7 + n, 0);
      chk(rd, {16'h0, cnt[n]});
    end
    conclude();
  end
endmodule : tb
